// file: arp_pkg.sv
// Shared constants for the converter result output port
package arp_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_ISTAT = 8'h08;
  localparam logic [7:0] A_ICLR = 8'h0C;
  localparam logic [7:0] A_IEN = 8'h10;
  localparam logic [7:0] A_RES = 8'h14;
  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_W = 9;
  localparam int unsigned C_PORT = 0;
  localparam int unsigned C_CODE = 1;
  localparam int unsigned C_CLKSRC = 2;
  localparam int unsigned C_FPOL = 3;
  localparam int unsigned C_SINV = 4;
  localparam int unsigned C_BSWAP = 5;
  localparam int unsigned C_DIV = 7;
  localparam logic [8:0] CTRL_RST = 9'h002;
  // ---------------------------------------------------------------
  // Interrupt and status fields
  // ---------------------------------------------------------------
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned I_CONV = 0;
  localparam int unsigned I_RDONE = 1;
  localparam int unsigned I_RDERR = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // ---------------------------------------------------------------
  // Serial timing and data
  // ---------------------------------------------------------------
  localparam int unsigned RES_BITS = 16;
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned SCLK_HALF_NS = 20;
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] SER_OE = 16'hFD00;
  localparam logic [3:0] PIN_RST = 4'h3;
  typedef enum logic [1:0] {MS_IDLE, MS_LOW, MS_HIGH} arp_mst_e;
  typedef enum logic [1:0] {SS_IDLE, SS_SHIFT, SS_DROP} arp_slv_e;
endpackage : arp_pkg

// file: arp_clk_if.sv
// Link between the port engine and its serial clock divider
`timescale 1ns/1ps
`default_nettype none
interface arp_clk_if;
  logic en;
  logic [1:0] div;
  logic tick;
  modport gen (input en, input div, output tick);
  modport user (output en, output div, input tick);
endinterface : arp_clk_if
`default_nettype wire

// file: arp_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module arp_sync #(
  parameter int unsigned W = 4,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  // First stage feeds only the second one
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= RST;
      dout <= RST;
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : arp_sync
`default_nettype wire

// file: arp_clkdiv.sv
// Half-period tick generator for the internally made serial clock
`timescale 1ns/1ps
`default_nettype none
module arp_clkdiv #(
  parameter int unsigned HALF_CYC = arp_pkg::SCLK_HALF_CYC,
  parameter int unsigned CW = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Engine side
  arp_clk_if.gen c
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] lim;

  // Each divider step doubles the half period
  assign lim = CW'((HALF_CYC << c.div) - 1);
  assign c.tick = c.en && (cnt == lim);

  // Counter restarts whenever the engine stops asking for ticks
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (ce) begin
      if (!c.en || c.tick) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule : arp_clkdiv
`default_nettype wire

// file: arp_port.sv
// Result output port: parallel bus or serial master/slave, Wishbone registers
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module arp_port #(
  parameter int unsigned BITS = arp_pkg::RES_BITS
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Converter core
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic [BITS-1:0] conv_result,
  // Host pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic sclk_in,
  input wire logic read_mode_or_chain_input,
  output logic [15:0] d_out,
  output logic [15:0] d_oe,
  // Interrupt
  output logic irq
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [arp_pkg::CTRL_W-1:0] ctrl;
  logic [arp_pkg::IRQ_W-1:0] istat;
  logic [arp_pkg::IRQ_W-1:0] ien;
  logic [arp_pkg::IRQ_W-1:0] ev;
  logic [BITS-1:0] res_raw;
  logic [BITS-1:0] res_fmt;
  logic [BITS-1:0] sh;
  logic [4:0] bit_cnt;
  logic [3:0] pins;
  logic cs_s, rd_s, sclk_s, mode_s;
  logic sclk_d, upd_edge, bus_en;
  logic serial, ext, fpol, sinv, master;
  logic busy_d, read_req, trig, rderr_q, rdone;
  logic sdo, frame, ms_busy;
  logic wr, rd_hit;
  logic [15:0] next_d_out;
  logic [15:0] next_d_oe;
  arp_pkg::arp_mst_e ms;
  arp_pkg::arp_slv_e ss;
  arp_clk_if ck ();

  // ---------------------------------------------------------------
  // Pin synchronisers and mode decode
  // ---------------------------------------------------------------
  arp_sync #(.W(4), .RST(arp_pkg::PIN_RST)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .din({read_mode_or_chain_input, sclk_in, rd_n, cs_n}),
    .dout(pins)
  );
  assign cs_s = pins[0];
  assign rd_s = pins[1];
  assign sclk_s = pins[2];
  assign mode_s = pins[3];
  assign serial = ctrl[arp_pkg::C_PORT];
  assign ext = ctrl[arp_pkg::C_CLKSRC];
  assign fpol = ctrl[arp_pkg::C_FPOL];
  assign sinv = ctrl[arp_pkg::C_SINV];
  assign master = serial && !ext;
  assign bus_en = !cs_s && !rd_s;

  // Clock input edge detect, seen through the invert select
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d <= 1'b0;
      busy_d <= 1'b0;
    end else if (ce) begin
      sclk_d <= sclk_s ^ sinv;
      busy_d <= conv_busy;
    end
  end
  // Chip select gates the external clock; inverted clock swaps edges
  assign upd_edge = !cs_s && (sclk_s ^ sinv) && !sclk_d;

  // ---------------------------------------------------------------
  // Result capture and output code
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      res_raw <= '0;
    end else if (ce && conv_done) begin
      res_raw <= conv_result;
    end
  end
  // Format applied at the output so a code change takes effect at once
  assign res_fmt = {res_raw[BITS-1] ^ ~ctrl[arp_pkg::C_CODE], res_raw[BITS-2:0]};

  // ---------------------------------------------------------------
  // Internal serial clock divider
  // ---------------------------------------------------------------
  // Divider honoured only in master read-after-convert
  assign ck.div = (master && !mode_s) ? ctrl[arp_pkg::C_DIV +: 2] : 2'h0;
  assign ck.en = master && ms_busy;
  arp_clkdiv u_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .c(ck.gen)
  );

  // ---------------------------------------------------------------
  // Master read trigger
  // ---------------------------------------------------------------
  // Mode high reads previous result at conversion start, low after it
  assign trig = mode_s ? (conv_busy && !busy_d) : conv_done;
  assign ms_busy = (ms != arp_pkg::MS_IDLE);

  // Request waits for the host to open the bus
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      read_req <= 1'b0;
    end else if (ce) begin
      if (master && trig) begin
        read_req <= 1'b1;
      end else if (!master || (bus_en && !ms_busy)) begin
        read_req <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial engine: shift register, bit count, both state machines
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ms <= arp_pkg::MS_IDLE;
      ss <= arp_pkg::SS_IDLE;
      sh <= '0;
      bit_cnt <= '0;
      rderr_q <= 1'b0;
      rdone <= 1'b0;
    end else if (ce) begin
      rderr_q <= 1'b0;
      rdone <= 1'b0;
      case (ms)
        arp_pkg::MS_IDLE: begin
          if (master && read_req && bus_en) begin
            ms <= arp_pkg::MS_LOW;
            sh <= res_fmt;
            bit_cnt <= '0;
          end
        end
        arp_pkg::MS_LOW: begin
          if (ck.tick) begin
            ms <= arp_pkg::MS_HIGH;
          end
        end
        arp_pkg::MS_HIGH: begin
          // Data moves only on the falling half, so the rising edge sees it settled
          if (ck.tick) begin
            sh <= {sh[BITS-2:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'(BITS - 1)) begin
              ms <= arp_pkg::MS_IDLE;
              rdone <= 1'b1;
            end else begin
              ms <= arp_pkg::MS_LOW;
            end
          end
        end
        default: ms <= arp_pkg::MS_IDLE;
      endcase
      case (ss)
        arp_pkg::SS_IDLE: begin
          if (serial && ext && !cs_s) begin
            ss <= arp_pkg::SS_SHIFT;
            sh <= res_fmt;
            bit_cnt <= '0;
          end
        end
        arp_pkg::SS_SHIFT: begin
          if (cs_s) begin
            ss <= arp_pkg::SS_IDLE;
          end else if (conv_done && bit_cnt != 5'(BITS)) begin
            ss <= arp_pkg::SS_DROP;
            rderr_q <= 1'b1;
          end else if (upd_edge) begin
            // First edge shows the MSB; later edges pull chain data in
            if (bit_cnt != 5'h00) begin
              sh <= {sh[BITS-2:0], mode_s};
            end
            if (bit_cnt != 5'(BITS)) begin
              bit_cnt <= bit_cnt + 5'h01;
            end
            if (bit_cnt == 5'(BITS - 1)) begin
              rdone <= 1'b1;
            end
          end
        end
        arp_pkg::SS_DROP: begin
          // Aborted read stays silent until select is released
          if (cs_s) begin
            ss <= arp_pkg::SS_IDLE;
          end
        end
        default: ss <= arp_pkg::SS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin composition
  // ---------------------------------------------------------------
  // Idle output is low outside a read
  assign sdo = ext ? (ss == arp_pkg::SS_SHIFT && sh[BITS-1]) : (ms_busy && sh[BITS-1]);
  assign frame = ms_busy ^ fpol;

  always_comb begin
    next_d_out = '0;
    next_d_oe = '0;
    if (!serial) begin
      next_d_out = ctrl[arp_pkg::C_BSWAP] ? {res_fmt[7:0], res_fmt[15:8]} : res_fmt;
      next_d_oe = bus_en ? 16'hFFFF : 16'h0000;
    end else begin
      next_d_out[8] = sdo;
      next_d_out[9] = (ms == arp_pkg::MS_HIGH) ^ sinv;
      next_d_out[10] = frame;
      next_d_out[11] = rderr_q;
      // Low pins stay off; clock pin driven only as master
      next_d_oe = bus_en ? (arp_pkg::SER_OE | {6'h00, master, 9'h000}) : 16'h0000;
    end
  end

  // Pins registered so they switch cleanly on the clock
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      d_out <= '0;
      d_oe <= '0;
    end else if (ce) begin
      d_out <= next_d_out;
      d_oe <= next_d_oe;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, clear and enable
  // ---------------------------------------------------------------
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign ev = {rderr_q, rdone, conv_done};

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      istat <= arp_pkg::IRQ_RST;
    end else if (ce) begin
      if (wr && wb_adr_i == arp_pkg::A_ICLR && wb_sel_i[0]) begin
        istat <= (istat & ~wb_dat_i[arp_pkg::IRQ_W-1:0]) | ev;
      end else begin
        istat <= istat | ev;
      end
    end
  end
  assign irq = |(istat & ien);

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Writes land on the edge where ack is seen high
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= arp_pkg::CTRL_RST;
      ien <= arp_pkg::IRQ_RST;
    end else if (ce && wr) begin
      if (wb_adr_i == arp_pkg::A_CTRL) begin
        if (wb_sel_i[0]) begin
          ctrl[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          ctrl[8] <= wb_dat_i[8];
        end
      end
      if (wb_adr_i == arp_pkg::A_IEN && wb_sel_i[0]) begin
        ien <= wb_dat_i[arp_pkg::IRQ_W-1:0];
      end
    end
  end

  // Read data captured with the request; unmapped reads give zero
  assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= '0;
    end else if (ce && rd_hit) begin
      case (wb_adr_i)
        arp_pkg::A_CTRL: wb_dat_o <= {23'h000000, ctrl};
        arp_pkg::A_STAT: wb_dat_o <= {24'h000000, bit_cnt, read_req, ss != arp_pkg::SS_IDLE, ms_busy};
        arp_pkg::A_ISTAT: wb_dat_o <= {29'h00000000, istat};
        arp_pkg::A_IEN: wb_dat_o <= {29'h00000000, ien};
        arp_pkg::A_RES: wb_dat_o <= {16'h0000, res_fmt};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_overrun;
    ce && ss == arp_pkg::SS_SHIFT && !cs_s && conv_done && bit_cnt != 5'(BITS);
  endsequence
  sequence s_flag_pulse;
    rderr_q ##1 (!rderr_q || !ce);
  endsequence
  sequence s_master_end;
    ce && ms == arp_pkg::MS_HIGH && ck.tick && bit_cnt == 5'(BITS - 1);
  endsequence

  AST_SER_LOW_HIZ: assert property (serial |-> next_d_oe[1:0] == 2'h0)
    else $error("low data pins driven in serial mode");
  AST_BUS_GATED: assert property (!bus_en |-> next_d_oe == 16'h0000)
    else $error("output bus enabled without select and read");
  AST_CODE_FMT: assert property (res_fmt[BITS-1] == (res_raw[BITS-1] ^ !ctrl[arp_pkg::C_CODE]))
    else $error("MSB does not follow output code select");
  AST_BYTE_SWAP: assert property (!serial && ctrl[arp_pkg::C_BSWAP] |-> next_d_out[7:0] == res_fmt[15:8])
    else $error("bytes not swapped in parallel mode");
  AST_FRAME: assert property (serial |-> next_d_out[10] == (ms_busy ^ fpol))
    else $error("frame marker level wrong");
  AST_SIXTEEN: assert property (s_master_end |=> ms == arp_pkg::MS_IDLE && bit_cnt == 5'(BITS) && !sdo)
    else $error("master read did not end after sixteen bits");
  AST_DIV_IGNORED: assert property (!(master && !mode_s) |-> ck.div == 2'h0)
    else $error("divider applied outside master read-after-convert");
  AST_OVERRUN: assert property (s_overrun |=> ss == arp_pkg::SS_DROP ##0 s_flag_pulse)
    else $error("overrun did not pulse the flag and drop the read");
  AST_SLAVE_EDGE: assert property (ce && ext && ss == arp_pkg::SS_SHIFT && !upd_edge && !conv_done |=> $stable(sh))
    else $error("slave data moved off the update edge");
  AST_MASTER_HOLD: assert property (ce && ms == arp_pkg::MS_LOW ##1 ce && ms == arp_pkg::MS_HIGH |-> $stable(sh))
    else $error("master data changed on the rising half");
  AST_IRQ: assert property (irq == |(istat & ien))
    else $error("interrupt output disagrees with status and enable");
endmodule : arp_port
`default_nettype wire

// file: arp_host_model.sv
// Host-side model of the converter port: select, read strobe, serial clock and chain pins
`timescale 1ns/1ps
`default_nettype none
module arp_host_model (
  // Clock
  input wire logic ref_clk,
  // Device pins
  input wire logic [15:0] d_out,
  input wire logic [15:0] d_oe,
  // Host-driven pins
  output logic cs_n,
  output logic rd_n,
  output logic sclk_in,
  output logic chain
);
  // Pins start deselected; the host clock stands still at its idle level
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    sclk_in = 1'b0;
    chain = 1'b0;
  end

  // Bus output enabled only while both strobes are held low
  task automatic enable(input logic on, input logic idle_lvl, input logic chain_lvl);
    @(posedge ref_clk);
    cs_n <= ~on;
    rd_n <= ~on;
    sclk_in <= idle_lvl;
    chain <= chain_lvl;
  endtask : enable

  // Host supplies the clock; data is taken at the end of the half after the update edge
  task automatic clock_in(input int edges, input int half, input logic inv, output logic [15:0] bits);
    bits = '0;
    for (int e = 0; e < edges; e++) begin
      @(posedge ref_clk);
      sclk_in <= ~inv;
      repeat (half) @(posedge ref_clk);
      bits = {bits[14:0], d_oe[8] ? d_out[8] : ~d_out[8]}; // Undriven pin reads as the inverse
      sclk_in <= inv;
      repeat (half - 1) @(posedge ref_clk);
    end
  endtask : clock_in

  // Master read: sample data and frame at each rise of the device clock, measure the span
  task automatic clock_out(output logic [15:0] bits, output logic [1:0] frm, output int got, output int sp);
    logic prev;
    prev = d_out[9];
    bits = '0;
    frm = 2'b10;
    got = 0;
    sp = 0;
    for (int c = 0; c < 4000 && got < 16; c++) begin
      @(posedge ref_clk);
      if (d_out[9] === 1'b1 && prev === 1'b0) begin
        if (got == 0) sp = c;
        bits = {bits[14:0], d_oe[8] ? d_out[8] : ~d_out[8]}; // Undriven pin reads as the inverse
        frm = {frm[1] & d_out[10], frm[0] | d_out[10]};
        got++;
        if (got == 16) sp = c - sp;
      end
      prev = d_out[9];
    end
  endtask : clock_out
endmodule : arp_host_model
`default_nettype wire

// file: tb.sv
// Self-checking bench for the converter result output port
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [15:0] RES = 16'hA5C3;
  logic ref_clk = 1'b0;
  logic nrst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, conv_busy, conv_done, irq;
  logic cs_n, rd_n, sclk_in, chain;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] conv_result, d_out, d_oe, bits;
  int miscompares = 0;
  int comparisons = 0;
  // ---------------------------------------------------------------
  // Clock, device and host
  // ---------------------------------------------------------------
  always #2 ref_clk = ~ref_clk;
  arp_port i_arp_port (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .conv_busy(conv_busy), .conv_done(conv_done), .conv_result(conv_result),
    .cs_n(cs_n), .rd_n(rd_n), .sclk_in(sclk_in), .read_mode_or_chain_input(chain), .d_out(d_out),
    .d_oe(d_oe), .irq(irq));
  arp_host_model i_arp_host_model (.ref_clk(ref_clk), .d_out(d_out), .d_oe(d_oe), .cs_n(cs_n),
    .rd_n(rd_n), .sclk_in(sclk_in), .chain(chain));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  // Classic cycle: hold everything until ack is sampled, then release for at least one cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      wrap_up();
    end
  endtask : wb

  // Busy for a few cycles, then a one-cycle done pulse carrying the result
  task automatic convert(input logic [15:0] r);
    @(posedge ref_clk);
    conv_busy <= 1'b1;
    idle(3);
    conv_busy <= 1'b0;
    conv_done <= 1'b1;
    conv_result <= r;
    @(posedge ref_clk);
    conv_done <= 1'b0;
  endtask : convert
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_parallel;
    logic [15:0] e;
    wb(1'b0, 8'h18, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    convert(RES);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, arp_pkg::A_CTRL, {26'h0, i[1], 3'h0, i[0], 1'b0}, rd);
      i_arp_host_model.enable(1'b1, 1'b0, 1'b0);
      idle(4);
      e = i[0] ? RES : RES ^ 16'h8000;
      chk("par data", d_out, i[1] ? {e[7:0], e[15:8]} : e);
      chk("par oe", d_oe, 16'hFFFF);
      i_arp_host_model.enable(1'b0, 1'b0, 1'b0);
      idle(4);
      chk("par off", d_oe, 16'h0000);
    end
    wb(1'b0, arp_pkg::A_RES, 32'h0, rd);
    chk("res reg", rd, {16'h0000, RES});
  endtask : s_parallel

  task automatic s_master(input logic fpol, input logic [1:0] div, input logic code, input logic mode,
                          input logic [15:0] nxt, input logic [15:0] exp, input int span);
    logic [1:0] frm;
    int got, sp;
    wb(1'b1, arp_pkg::A_CTRL, {23'h0, div, 3'h0, fpol, 1'b0, code, 1'b1}, rd);
    i_arp_host_model.enable(1'b1, 1'b0, mode);
    idle(4);
    chk("mst oe", d_oe & 16'h0303, 16'h0300);
    fork
      convert(nxt);
      i_arp_host_model.clock_out(bits, frm, got, sp);
    join
    chk("mst bits", bits, exp);
    chk("mst count", got, 16);
    chk("mst frame", frm, {~fpol, ~fpol});
    chk("mst span", sp, span);
    idle(20);
    chk("mst idle", {d_out[10], d_out[8]}, {fpol, 1'b0});
    i_arp_host_model.enable(1'b0, 1'b0, 1'b0);
  endtask : s_master

  task automatic s_slave;
    i_arp_host_model.enable(1'b0, 1'b1, 1'b1);
    wb(1'b1, arp_pkg::A_CTRL, 32'h17, rd);
    convert(RES);
    i_arp_host_model.enable(1'b1, 1'b1, 1'b0);
    idle(6);
    chk("slv oe", d_oe & 16'h0303, 16'h0100);
    i_arp_host_model.clock_in(16, 6, 1'b1, bits);
    chk("slv bits", bits, RES);
    i_arp_host_model.clock_in(1, 6, 1'b1, bits);
    chk("slv chain", bits[0], 1'b0);
    i_arp_host_model.enable(1'b0, 1'b1, 1'b0);
    idle(4);
  endtask : s_slave

  // Slave read cut short by the next conversion; the flag also drives the interrupt
  task automatic s_overrun;
    logic seen;
    seen = 1'b0;
    wb(1'b1, arp_pkg::A_IEN, 32'h4, rd);
    idle(1);
    chk("irq masked", irq, 1'b0);
    wb(1'b1, arp_pkg::A_CTRL, 32'h7, rd);
    convert(RES);
    i_arp_host_model.enable(1'b1, 1'b0, 1'b0);
    idle(4);
    i_arp_host_model.clock_in(4, 6, 1'b0, bits);
    convert(RES);
    for (int c = 0; c < 12; c++) begin
      @(posedge ref_clk);
      seen = seen | (d_out[11] === 1'b1);
    end
    chk("flag pulse", seen, 1'b1);
    chk("drop data", d_out[8], 1'b0);
    chk("irq set", irq, 1'b1);
    wb(1'b0, arp_pkg::A_ISTAT, 32'h0, rd);
    chk("istat err", rd[2], 1'b1);
    wb(1'b1, arp_pkg::A_ICLR, 32'h7, rd);
    idle(1);
    chk("irq clear", irq, 1'b0);
    i_arp_host_model.enable(1'b0, 1'b0, 1'b0);
  endtask : s_overrun
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    conv_busy = 1'b0;
    conv_done = 1'b0;
    conv_result = 16'h0000;
    idle(4);
    nrst <= 1'b1;
    idle(3);
    s_parallel();
    s_master(1'b0, 2'h0, 1'b1, 1'b0, RES, RES, 150);
    s_master(1'b1, 2'h1, 1'b0, 1'b0, RES, RES ^ 16'h8000, 300);
    s_master(1'b0, 2'h1, 1'b1, 1'b1, 16'h0F0F, RES, 150);
    s_slave();
    s_overrun();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
